// ### srbc_ctrl_model.sv
// Purpose: Memory controller model issuing read and activate commands
// Assumes: Commands change right after a rising edge
// Notes:   Commands from issue wait GAP clocks after the last read; issue_raw does not wait
`timescale 1ns/1ns
module srbc_ctrl_model #(
   parameter logic [7:0] GAP = 8'h20
) (
   input  wire logic             clk_i,
   output srbc_pkg::srbc_cmd_type cmd_o
);
   logic [7:0] since = 8'hFF;
   initial cmd_o = '0;
   always_ff @(posedge clk_i) begin
      since <= cmd_o.read ? 8'h01 : ((since == 8'hFF) ? since : since + 8'h01);
   end
   task automatic issue(input logic rd, input logic act, input logic a10, input logic a12,
                        input logic [3:0] bank);
      @(posedge clk_i);
      while (since < GAP) @(posedge clk_i);
      cmd_o <= {rd, 1'b0, act, 1'b0, bank, a10, a12};
      @(posedge clk_i);
      // Released address lines show the inverse
      cmd_o <= {4'h0, ~bank, ~a10, ~a12};
   endtask
   // Skips the spacing wait to provoke spacing faults
   task automatic issue_raw(input logic [3:0] kind, input logic [3:0] bank);
      @(posedge clk_i);
      cmd_o <= {kind, bank, 2'h0};
      @(posedge clk_i);
      cmd_o <= {4'h0, ~bank, 2'h3};
   endtask
endmodule

// ### srbc_defines.svh
// Purpose: Constants for the read-burst control block
// Assumes: 100 MHz clock, APB register access
// Notes:   Offsets, fields, reset values and timing counts
`ifndef SRBC_DEFINES_SVH
`define SRBC_DEFINES_SVH

`define SRBC_OFS_MODE          8'h00
`define SRBC_OFS_STATUS        8'h04
`define SRBC_OFS_VIOL          8'h08

`define SRBC_MODE_BURST_LSB    0
`define SRBC_MODE_RPRE2_BIT    2
`define SRBC_MODE_WPRE2_BIT    3
`define SRBC_MODE_CAS_LSB      4
`define SRBC_MODE_ADD_LSB      9
`define SRBC_MODE_CASW_LSB     14
`define SRBC_MODE_USED_MASK    32'h0007FFFF

`define SRBC_BURST_FULL        2'h0
`define SRBC_BURST_PERCMD      2'h1
`define SRBC_BURST_CHOP        2'h2

`define SRBC_RST_CAS           5'h0B
`define SRBC_RST_ADD           5'h00
`define SRBC_RST_CASW          5'h09
`define SRBC_CASW_LOWEST       5'h09

`define SRBC_FULL_CLOCKS       3'h4
`define SRBC_CHOP_CLOCKS       3'h2

`define SRBC_BAD_RD_SPACING    8'h05

`define SRBC_CLK_PERIOD_PS     10000
`define SRBC_RTP_MIN_PS        7500
`define SRBC_RTP_MIN_CK        4
`define SRBC_RTP_PS_CK         ((`SRBC_RTP_MIN_PS + `SRBC_CLK_PERIOD_PS - 1) / `SRBC_CLK_PERIOD_PS)
`define SRBC_RTP_CK            ((`SRBC_RTP_PS_CK > `SRBC_RTP_MIN_CK) ? `SRBC_RTP_PS_CK : `SRBC_RTP_MIN_CK)

`define SRBC_LINE_DEPTH        64
`define SRBC_RDLAT_MAX         6'h3C

`endif

// ### srbc_pkg.sv
// Purpose: Types shared by the read-burst control block
// Assumes: Constants come from srbc_defines.svh
// Notes:   Command bundle and delay-line slot
package srbc_pkg;

   typedef struct packed {
      logic       read;
      logic       write;
      logic       activate;
      logic       precharge;
      logic [3:0] bank;
      logic       autoclose_address_bit;
      logic       burst_select_address_bit;
   } srbc_cmd_type;

   typedef struct packed {
      logic       valid;
      logic       chop;
      logic       autoclose;
      logic [3:0] bank;
   } srbc_slot_type;

endpackage

// ### srbc_props.sv
// Purpose: Port assertions for the read-burst block
// Assumes: Reads far enough apart that strobe windows never merge
// Notes:   Bound into srbc_read_burst below
`timescale 1ns/1ns
module srbc_props (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic dq_oe_o,
   input wire logic dqs_oe_o,
   input wire logic dqs_preamble_o,
   input wire logic close_pulse_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   sequence s_chop_end;
      !dq_oe_o;
   endsequence
   sequence s_full_end;
      dq_oe_o ##1 dq_oe_o ##1 !dq_oe_o;
   endsequence
   a_pre_before_data: assert property ($rose(dq_oe_o) |-> $past(dqs_preamble_o))
      else $error("data without preamble");
   a_pre_bounded: assert property ($rose(dqs_preamble_o) |-> ##[1:2] !dqs_preamble_o)
      else $error("preamble too long");
   a_pre_no_data: assert property (dqs_preamble_o |-> dqs_oe_o && !dq_oe_o)
      else $error("preamble overlaps data");
   a_data_in_strobe: assert property (dq_oe_o |-> dqs_oe_o)
      else $error("data without strobe");
   a_burst_release: assert property ($rose(dq_oe_o) |-> ##2 (s_chop_end or s_full_end))
      else $error("data lines held wrong length");
   a_postamble_one: assert property ($fell(dq_oe_o) |-> dqs_oe_o ##1 !dqs_oe_o)
      else $error("postamble not one clock");
   a_close_after_data: assert property (close_pulse_o |-> $past(dq_oe_o) && !dq_oe_o)
      else $error("close not at burst end");
   a_close_single: assert property (close_pulse_o |=> !close_pulse_o)
      else $error("close pulse too long");
endmodule

bind srbc_read_burst srbc_props props_i (
   .clk_i          (clk_i),
   .rstn_i         (rstn_i),
   .dq_oe_o        (dq_oe_o),
   .dqs_oe_o       (dqs_oe_o),
   .dqs_preamble_o (dqs_preamble_o),
   .close_pulse_o  (close_pulse_o)
);

// ### srbc_read_burst.sv
// Purpose: Read-burst scheduling, strobe windows and auto close of a DRAM
// Assumes: Commands are synchronous to clk_i; APB slave with one wait state
// Notes:   Read latency limited to 60 clocks by the delay line depth
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ns
`include "srbc_defines.svh"

// Overview of operation
// RQ1 - In per-command mode, address bit twelve low chops, high gives eight beats.
// RQ2 - Read with autoclose bit low leaves the bank open.
// RQ3 - Read with autoclose bit high closes the bank after the burst.
// RQ4 - Mode bits 1:0: 00 full, 01 per-command, 10 chopped.
// RQ5 - Read latency is additive plus CAS latency. The code clamps sums above 60 clocks to 60.
// RQ6 - Controller must not space reads five clocks apart with two-clock preamble.
// RQ7 - Two-clock write preamble wants CAS write latency above lowest setting.
// RQ8 - Read preamble is one or two clocks before strobe toggling.
// RQ9 - Read-to-write spacing at least CAS minus write latency, half burst, one, preamble.
// RQ10 - Data lines released four clocks after latency, two for chopped burst.
// RQ11 - Read-to-close spacing at least additive latency plus internal read-close delay.
// RQ12 - Chopped burst moves four beats only, then strobe postamble releases.
module srbc_read_burst (
   input  wire logic                 clk_i,
   input  wire logic                 rstn_i,
   input  wire srbc_pkg::srbc_cmd_type cmd_i,
   input  wire logic                 psel_i,
   input  wire logic                 penable_i,
   input  wire logic                 pwrite_i,
   input  wire logic [7:0]           paddr_i,
   input  wire logic [31:0]          pwdata_i,
   output logic                      pready_o,
   output logic [31:0]               prdata_o,
   output logic                      pslverr_o,
   output logic                      dq_oe_o,
   output logic                      dqs_oe_o,
   output logic                      dqs_preamble_o,
   output logic                      close_pulse_o,
   output logic [3:0]                close_bank_o
);

   logic [31:0]            mode_reg;
   logic [3:0]             viol;
   logic [15:0]            bank_open;
   srbc_pkg::srbc_slot_type line [`SRBC_LINE_DEPTH];
   srbc_pkg::srbc_slot_type new_slot;
   srbc_pkg::srbc_slot_type tap_pre;
   srbc_pkg::srbc_slot_type tap_data;
   srbc_pkg::srbc_slot_type tap_close_full;
   srbc_pkg::srbc_slot_type tap_close_chop;
   logic [1:0]             burst_mode;
   logic                   rpre2;
   logic                   wpre2;
   logic [4:0]             cas_lat;
   logic [4:0]             add_lat;
   logic [4:0]             casw_lat;
   logic [5:0]             rd_lat;
   logic [5:0]             pre_len;
   logic                   cmd_chop;
   logic [2:0]             dq_cnt;
   logic [2:0]             next_dq_cnt;
   logic [7:0]             since_rd;
   logic                   last_chop;
   logic [3:0]             last_bank;
   logic [7:0]             rtw_sum;
   logic [7:0]             rtw_min;
   logic [7:0]             rtp_min;
   logic [3:0]             new_viol;
   logic                   apb_access;
   logic                   apb_write;

   assign burst_mode = mode_reg[`SRBC_MODE_BURST_LSB +: 2];
   assign rpre2      = mode_reg[`SRBC_MODE_RPRE2_BIT];
   assign wpre2      = mode_reg[`SRBC_MODE_WPRE2_BIT];
   assign cas_lat    = mode_reg[`SRBC_MODE_CAS_LSB +: 5];
   assign add_lat    = mode_reg[`SRBC_MODE_ADD_LSB +: 5];
   assign casw_lat   = mode_reg[`SRBC_MODE_CASW_LSB +: 5];

   // Latency clamped so the close taps stay inside the line
   always_comb begin
      logic [5:0] sum;
      sum    = {1'b0, add_lat} + {1'b0, cas_lat};  // [RQ5]
      rd_lat = (sum > `SRBC_RDLAT_MAX) ? `SRBC_RDLAT_MAX : sum;
   end

   assign pre_len = rpre2 ? 6'h02 : 6'h01;  // [RQ8]

   always_comb begin
      case (burst_mode)  // [RQ4]
         `SRBC_BURST_PERCMD: cmd_chop = ~cmd_i.burst_select_address_bit;  // [RQ1]
         `SRBC_BURST_CHOP:   cmd_chop = 1'b1;
         default:            cmd_chop = 1'b0;
      endcase
   end

   always_comb begin
      new_slot.valid     = cmd_i.read;
      new_slot.chop      = cmd_chop;
      new_slot.autoclose = cmd_i.autoclose_address_bit;  // [RQ2] [RQ3]
      new_slot.bank      = cmd_i.bank;
   end

   // Taps: entry k ages k+1 clocks past the command edge
   assign tap_pre        = (rd_lat > pre_len) ? line[rd_lat - pre_len - 6'h01] : new_slot;
   assign tap_data       = line[rd_lat - 6'h01];
   assign tap_close_chop = line[rd_lat + 6'h01];
   assign tap_close_full = line[rd_lat + 6'h03];

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < `SRBC_LINE_DEPTH; i++) begin
            line[i] <= '0;
         end
      end else begin
         line[0] <= new_slot;
         for (int i = 1; i < `SRBC_LINE_DEPTH; i++) begin
            line[i] <= line[i - 1];
         end
      end
   end

   always_comb begin
      if (tap_data.valid) begin
         next_dq_cnt = tap_data.chop ? `SRBC_CHOP_CLOCKS : `SRBC_FULL_CLOCKS;  // [RQ10] [RQ12]
      end else if (dq_cnt != 3'h0) begin
         next_dq_cnt = dq_cnt - 3'h1;
      end else begin
         next_dq_cnt = 3'h0;
      end
   end

   // Data window, strobe preamble and one-clock postamble
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         dq_cnt         <= 3'h0;
         dq_oe_o        <= 1'b0;
         dqs_oe_o       <= 1'b0;
         dqs_preamble_o <= 1'b0;
      end else begin
         dq_cnt         <= next_dq_cnt;
         dq_oe_o        <= (next_dq_cnt != 3'h0);  // [RQ10]
         dqs_preamble_o <= (next_dq_cnt == 3'h0) &&
                           ((tap_pre.valid && dq_cnt == 3'h0) || dqs_preamble_o);  // [RQ8]
         dqs_oe_o       <= (next_dq_cnt != 3'h0) || (dq_cnt == 3'h1) ||
                           (tap_pre.valid && dq_cnt == 3'h0) ||
                           (dqs_preamble_o && !tap_data.valid) ||
                           (dqs_preamble_o && tap_data.valid);  // [RQ12]
      end
   end

   // Bank state: activate opens, autoclose read closes after its burst
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         bank_open     <= 16'h0000;
         close_pulse_o <= 1'b0;
         close_bank_o  <= 4'h0;
      end else begin
         close_pulse_o <= 1'b0;
         if (tap_close_chop.valid && tap_close_chop.chop && tap_close_chop.autoclose) begin
            bank_open[tap_close_chop.bank] <= 1'b0;  // [RQ3]
            close_pulse_o <= 1'b1;
            close_bank_o  <= tap_close_chop.bank;
         end else if (tap_close_full.valid && !tap_close_full.chop &&
                      tap_close_full.autoclose) begin
            bank_open[tap_close_full.bank] <= 1'b0;  // [RQ3]
            close_pulse_o <= 1'b1;
            close_bank_o  <= tap_close_full.bank;
         end
         if (cmd_i.precharge) begin
            bank_open[cmd_i.bank] <= 1'b0;
         end
         if (cmd_i.activate) begin
            bank_open[cmd_i.bank] <= 1'b1;
         end
      end
   end

   // Spacing monitor of controller commands
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         since_rd  <= 8'hFF;
         last_chop <= 1'b0;
         last_bank <= 4'h0;
      end else if (cmd_i.read) begin
         since_rd  <= 8'h01;
         last_chop <= cmd_chop;
         last_bank <= cmd_i.bank;
      end else if (since_rd != 8'hFF) begin
         since_rd  <= since_rd + 8'h01;
      end
   end

   always_comb begin
      rtw_sum = {3'h0, cas_lat} + (last_chop ? 8'h02 : 8'h04) + 8'h01 + (wpre2 ? 8'h02 : 8'h01);
      rtw_min = (rtw_sum > {3'h0, casw_lat}) ? (rtw_sum - {3'h0, casw_lat}) : 8'h00;  // [RQ9]
      rtp_min = {3'h0, add_lat} + 8'(`SRBC_RTP_CK);  // [RQ11]
      new_viol[0] = cmd_i.read && rpre2 && (since_rd == `SRBC_BAD_RD_SPACING);  // [RQ6]
      new_viol[1] = cmd_i.write && (since_rd < rtw_min);  // [RQ9]
      new_viol[2] = cmd_i.precharge && (cmd_i.bank == last_bank) && (since_rd < rtp_min);  // [RQ11]
      new_viol[3] = cmd_i.write && wpre2 && (casw_lat <= `SRBC_CASW_LOWEST);  // [RQ7]
   end

   assign apb_access = psel_i && penable_i && pready_o;
   assign apb_write  = apb_access && pwrite_i;

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         pready_o  <= 1'b0;
         prdata_o  <= 32'h00000000;
         pslverr_o <= 1'b0;
      end else begin
         pready_o  <= psel_i && penable_i && !pready_o;
         pslverr_o <= psel_i && penable_i && !pready_o &&
                      (paddr_i != `SRBC_OFS_MODE) && (paddr_i != `SRBC_OFS_STATUS) &&
                      (paddr_i != `SRBC_OFS_VIOL);
         case (paddr_i)
            `SRBC_OFS_MODE:   prdata_o <= mode_reg;
            `SRBC_OFS_STATUS: prdata_o <= {15'h0000, dq_oe_o, bank_open};
            `SRBC_OFS_VIOL:   prdata_o <= {28'h0000000, viol};
            default:          prdata_o <= 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         mode_reg <= {13'h0000, `SRBC_RST_CASW, `SRBC_RST_ADD, `SRBC_RST_CAS, 2'h0,
                      `SRBC_BURST_FULL};
      end else if (apb_write && paddr_i == `SRBC_OFS_MODE) begin
         mode_reg <= pwdata_i & `SRBC_MODE_USED_MASK;
      end
   end

   // Write one to clear; a new violation wins over the clear
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         viol <= 4'h0;
      end else if (apb_write && paddr_i == `SRBC_OFS_VIOL) begin
         viol <= (viol & ~pwdata_i[3:0]) | new_viol;
      end else begin
         viol <= viol | new_viol;
      end
   end

endmodule

// ### tb_top.sv
// Purpose: Self-checking bench for the read-burst block
// Assumes: Controller model spaces commands widely
// Notes:   Windows counted in clocks from the read edge
`timescale 1ns/1ns
`include "srbc_defines.svh"
`define CHK(g, e, m) begin tests_run++; if ((g) !== (e)) begin err_total++; \
   $display("unexpected at %0t: %s", $time, m); end end
module tb_top;
   logic                   clk_i = 1'b0;
   logic                   rstn_i = 1'b0;
   logic                   psel_i = 1'b0;
   logic                   penable_i = 1'b0;
   logic                   pwrite_i = 1'b0;
   logic [7:0]             paddr_i = 8'h00;
   logic [31:0]            pwdata_i = 32'h00000000;
   logic [31:0]            prdata_o;
   logic                   pready_o, pslverr_o, dq_oe_o, dqs_oe_o, dqs_preamble_o;
   logic                   close_pulse_o;
   logic [3:0]             close_bank_o;
   srbc_pkg::srbc_cmd_type cmd_i;
   int                     err_total = 0;
   int                     tests_run = 0;
   initial forever #5 clk_i = ~clk_i;
   srbc_ctrl_model srbc_ctrl_model_i (.clk_i(clk_i), .cmd_o(cmd_i));
   srbc_read_burst srbc_read_burst_i (.clk_i(clk_i), .rstn_i(rstn_i), .cmd_i(cmd_i),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
      .dq_oe_o(dq_oe_o), .dqs_oe_o(dqs_oe_o), .dqs_preamble_o(dqs_preamble_o),
      .close_pulse_o(close_pulse_o), .close_bank_o(close_bank_o));
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
      int n;
      n = 0;
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= wd;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      if (pready_o !== 1'b1) begin
         err_total++;
         tally_and_finish();
      end
   endtask
   function automatic logic [31:0] mode(input logic [1:0] b, input logic r2,
                                        input logic [4:0] add_lat);
      return {13'h0000, 5'h09, add_lat, 5'h0B, 1'b0, r2, b};
   endfunction
   task automatic burst(input logic [31:0] md, input logic a10, input logic a12,
                        input int lat, input int pre, input int len);
      logic [31:0] rd;
      logic        er;
      int          n, p, k;
      apb(1'b1, `SRBC_OFS_MODE, md, rd, er);
      srbc_ctrl_model_i.issue(1'b1, 1'b0, a10, a12, 4'h3);
      n = 0;
      p = 0;
      k = 0;
      while (dq_oe_o !== 1'b1 && n < 80) begin
         @(posedge clk_i);
         #1;
         n++;
         if (dqs_preamble_o === 1'b1 && p == 0) p = n;
      end
      while (dq_oe_o === 1'b1 && k < 80) begin
         @(posedge clk_i);
         #1;
         k++;
      end
      `CHK(n, lat, "read latency")
      `CHK(p, lat - pre, "preamble start")
      `CHK(k, len, "data clocks")
      `CHK(dqs_oe_o, 1'b1, "postamble")
      `CHK(close_pulse_o, a10, "auto close")
      if (a10) `CHK(close_bank_o, 4'h3, "closed bank")
      if (n >= 80 || k >= 80) begin
         err_total++;
         tally_and_finish();
      end
   endtask
   task automatic t_regs();
      logic [31:0] rd;
      logic        er;
      apb(1'b0, `SRBC_OFS_MODE, 32'h00000000, rd, er);
      `CHK(rd, 32'h000240B0, "mode reset")
      apb(1'b1, 8'h0C, 32'hFFFFFFFF, rd, er);
      apb(1'b0, 8'h0C, 32'h00000000, rd, er);
      `CHK({er, rd}, 33'h100000000, "unmapped read")
   endtask
   task automatic t_modes();
      burst(mode(2'h0, 1'b0, 5'h00), 1'b0, 1'b0, 11, 1, 4);
      burst(mode(2'h2, 1'b0, 5'h00), 1'b0, 1'b1, 11, 1, 2);
      burst(mode(2'h1, 1'b0, 5'h00), 1'b0, 1'b0, 11, 1, 2);
      burst(mode(2'h1, 1'b0, 5'h00), 1'b0, 1'b1, 11, 1, 4);
      burst(mode(2'h3, 1'b0, 5'h00), 1'b0, 1'b0, 11, 1, 4);
   endtask
   task automatic t_latency();
      burst(mode(2'h0, 1'b0, 5'h0A), 1'b0, 1'b1, 21, 1, 4);
      burst(mode(2'h0, 1'b1, 5'h0A), 1'b0, 1'b1, 21, 2, 4);
      burst(mode(2'h2, 1'b1, 5'h00), 1'b1, 1'b0, 11, 2, 2);
   endtask
   task automatic t_autoclose();
      logic [31:0] rd;
      logic        er;
      srbc_ctrl_model_i.issue(1'b0, 1'b1, 1'b0, 1'b0, 4'h3);
      burst(mode(2'h0, 1'b0, 5'h00), 1'b0, 1'b1, 11, 1, 4);
      apb(1'b0, `SRBC_OFS_STATUS, 32'h00000000, rd, er);
      `CHK(rd[3], 1'b1, "bank kept open")
      burst(mode(2'h0, 1'b0, 5'h00), 1'b1, 1'b1, 11, 1, 4);
      apb(1'b0, `SRBC_OFS_STATUS, 32'h00000000, rd, er);
      `CHK(rd[3], 1'b0, "bank closed")
   endtask
   task automatic t_viol();
      logic [31:0] rd;
      logic        er;
      apb(1'b1, `SRBC_OFS_MODE, mode(2'h0, 1'b0, 5'h00) | 32'h00000008, rd, er);
      srbc_ctrl_model_i.issue(1'b1, 1'b0, 1'b0, 1'b1, 4'h3);
      srbc_ctrl_model_i.issue_raw(4'h1, 4'h3);
      srbc_ctrl_model_i.issue_raw(4'h4, 4'h3);
      apb(1'b0, `SRBC_OFS_VIOL, 32'h00000000, rd, er);
      `CHK(rd, 32'h0000000E, "spacing faults")
      apb(1'b1, `SRBC_OFS_VIOL, 32'h0000000F, rd, er);
      apb(1'b0, `SRBC_OFS_VIOL, 32'h00000000, rd, er);
      `CHK(rd, 32'h00000000, "faults cleared")
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      rstn_i <= 1'b1;
      t_regs();
      t_modes();
      t_latency();
      t_autoclose();
      t_viol();
      tally_and_finish();
   end
endmodule
